//--- logic/vihc_ctrl.sv
// vihc_ctrl: hypervisor control, vm state, type register, maintenance and trap decode.
// assumes the list-register logic supplies valid/pending flags and deactivate events.
`timescale 1ns/1ps
module vihc_ctrl (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic [3:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [31:0] regRdata,
  input wire logic [3:0] listValid,
  input wire logic [3:0] listPending,
  input wire logic deactUnmatched,
  input wire logic deactMatched,
  input wire logic el1NonSecure,
  input wire logic accDeactWrite,
  input wire logic accGroup0,
  input wire logic accGroup1,
  input wire logic accCommon,
  output logic trapToEl2,
  output logic maintIrq,
  output logic vifEnable,
  output logic [7:0] virtualPriorityMask,
  output logic [2:0] effBinpointG1,
  output logic virtualEoiSplitMode,
  output logic virtualGroup0Enable,
  output logic virtualGroup1Enable,
  output logic g0AsFastIrq
);
  typedef struct packed {
    logic [4:0] count;
    logic [13:0] ctl;
    logic [7:0] pmr;
    logic [2:0] bp0;
    logic [2:0] bp1;
    logic eoim;
    logic cbpr;
    logic eng1;
    logic eng0;
    logic [31:0] rdata;
  } vihc_state_t;

  vihc_state_t st_q, st_d;
  logic [31:0] hcrView, vmcrView;
  logic [2:0] bp1Read, listValidCnt;
  logic [13:0] hcrLow;

  // hcr low field: bits 14:0 minus the hard-zero bits 13, 9, 8
  assign hcrLow = st_q.ctl;
  always_comb begin
    hcrView = {st_q.count, 12'h000, hcrLow[13], 1'b0, hcrLow[12:10], 2'b00, hcrLow[7:0]};
    vmcrView = {st_q.pmr, st_q.bp0, st_q.bp1, 8'h00, st_q.eoim, 4'h0, st_q.cbpr, 1'b1, 1'b0,
                st_q.eng1, st_q.eng0};
    bp1Read = (st_q.bp0 == vihc_pkg::BP_MAX) ? vihc_pkg::BP_MAX : st_q.bp0 + 3'h1;
    listValidCnt = 3'h0;
    for (int i = 0; i < vihc_pkg::LIST_ENTRIES; i++) begin
      listValidCnt = listValidCnt + {2'b00, listValid[i]};
    end
  end

  // ctl packs hcr bits {14,12,11,10,7..0} as [13]=trap_deactivate_writes,[12:10]=trap group 1, group 0 and common bits,[9:8] unused,[7:0]
  function automatic logic [13:0] packCtl(input logic [31:0] w);
    packCtl = {w[vihc_pkg::HCR_TRAP_DEACTIVATE_WRITES], w[vihc_pkg::HCR_TRAP_GROUP1_ACCESSES], w[vihc_pkg::HCR_TRAP_GROUP0_ACCESSES], w[vihc_pkg::HCR_TC],
               2'b00, w[7:0]};
  endfunction : packCtl

  always_comb begin
    logic [2:0] wbp;
    wbp = 3'h0;
    st_d = st_q;
    // count: hardware increments apply on top of a same-cycle software write; matched decrements too
    if (regWrite && regAddr == vihc_pkg::ADDR_HCR) begin
      st_d.count = regWdata[31:vihc_pkg::HCR_CNT_LSB];
      st_d.ctl = packCtl(regWdata & vihc_pkg::HCR_WMASK);
    end
    if (deactUnmatched && !deactMatched && st_d.count != 5'h1F) begin
      st_d.count = st_d.count + 5'h01;
    end else if (deactMatched && !deactUnmatched && st_d.count != 5'h00) begin
      st_d.count = st_d.count - 5'h01;
    end
    if (regWrite && regAddr == vihc_pkg::ADDR_VMCR) begin
      st_d.pmr = regWdata[31:vihc_pkg::VM_PMR_LSB];
      st_d.eoim = regWdata[vihc_pkg::VM_EOIM];
      st_d.cbpr = regWdata[vihc_pkg::VM_CBPR];
      st_d.eng1 = regWdata[vihc_pkg::VM_ENG1];
      st_d.eng0 = regWdata[vihc_pkg::VM_ENG0];
      wbp = regWdata[vihc_pkg::VM_BP0_LSB +: 3];
      st_d.bp0 = (wbp < vihc_pkg::BP0_MIN) ? vihc_pkg::BP0_MIN : wbp;
      wbp = regWdata[vihc_pkg::VM_BP1_LSB +: 3];
      st_d.bp1 = (wbp < vihc_pkg::BP1_MIN) ? vihc_pkg::BP1_MIN : wbp;
    end
    // the group 1 binary point view: writes dropped while common mode is on
    if (regWrite && regAddr == vihc_pkg::ADDR_BPR1 && !st_q.cbpr) begin
      st_d.bp1 = (regWdata[2:0] < vihc_pkg::BP1_MIN) ? vihc_pkg::BP1_MIN : regWdata[2:0];
    end
    st_d.rdata = 32'h0000_0000;
    if (regRead) begin
      unique case (regAddr)
        vihc_pkg::ADDR_HCR: st_d.rdata = hcrView;
        vihc_pkg::ADDR_VMCR: st_d.rdata = vmcrView;
        vihc_pkg::ADDR_VTR: st_d.rdata = vihc_pkg::VTR_VALUE;
        vihc_pkg::ADDR_BPR1: st_d.rdata = {29'h0, st_q.cbpr ? bp1Read : st_q.bp1};
        default: st_d.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      st_q <= '{count: 5'h00, ctl: 14'h0000, pmr: 8'h00, bp0: vihc_pkg::BP0_MIN, bp1: vihc_pkg::BP1_MIN,
                eoim: 1'b0, cbpr: 1'b0, eng1: 1'b0, eng0: 1'b0, rdata: 32'h0000_0000};
    end else begin
      st_q <= st_d;
    end
  end

  logic [6:0] maintCond;
  always_comb begin
    maintCond[6] = st_q.ctl[7] && !st_q.eng1;
    maintCond[5] = st_q.ctl[6] && st_q.eng1;
    maintCond[4] = st_q.ctl[5] && !st_q.eng0;
    maintCond[3] = st_q.ctl[4] && st_q.eng0;
    maintCond[2] = st_q.ctl[3] && (listPending == 4'h0);
    maintCond[1] = st_q.ctl[2] && (st_q.count != 5'h00);
    maintCond[0] = st_q.ctl[1] && (listValidCnt <= 3'h1);
  end
  assign maintIrq = st_q.ctl[vihc_pkg::HCR_EN] && (|maintCond);
  assign vifEnable = st_q.ctl[vihc_pkg::HCR_EN];

  // trap decode is combinational so the core sees it in the access cycle
  assign trapToEl2 = el1NonSecure && ((accDeactWrite && st_q.ctl[13])
                   || (accGroup1 && st_q.ctl[12])
                   || (accGroup0 && st_q.ctl[11])
                   || (accCommon && st_q.ctl[10]));

  assign regRdata = st_q.rdata;
  assign virtualPriorityMask = st_q.pmr;
  assign effBinpointG1 = st_q.cbpr ? st_q.bp0 : st_q.bp1;
  assign virtualEoiSplitMode = st_q.eoim;
  assign virtualGroup0Enable = st_q.eng0;
  assign virtualGroup1Enable = st_q.eng1;
  assign g0AsFastIrq = 1'b1;

  // second opinion on maintenance and trap, taken from the software view of the words
  logic expMaint, expTrap;
  logic [6:0] expCond;
  always_comb begin
    expCond = 7'h00;
    expCond[6] = hcrView[7] && !vmcrView[vihc_pkg::VM_ENG1];
    expCond[5] = hcrView[6] && vmcrView[vihc_pkg::VM_ENG1];
    expCond[4] = hcrView[5] && !vmcrView[vihc_pkg::VM_ENG0];
    expCond[3] = hcrView[4] && vmcrView[vihc_pkg::VM_ENG0];
    expCond[2] = hcrView[3] && !(|listPending);
    expCond[1] = hcrView[2] && (hcrView[31:vihc_pkg::HCR_CNT_LSB] != 5'h00);
    expCond[0] = hcrView[1] && ($countones(listValid) < 2);
    expMaint = hcrView[vihc_pkg::HCR_EN] && (|expCond);
    expTrap = el1NonSecure && ((accDeactWrite && hcrView[vihc_pkg::HCR_TRAP_DEACTIVATE_WRITES])
      || (accGroup1 && hcrView[vihc_pkg::HCR_TRAP_GROUP1_ACCESSES])
      || (accGroup0 && hcrView[vihc_pkg::HCR_TRAP_GROUP0_ACCESSES])
      || (accCommon && hcrView[vihc_pkg::HCR_TC]));
  end

  chk_maint_g1_off: assert property (@(posedge ref_clk) disable iff (!rstn)
    (st_q.ctl[0] && st_q.ctl[7] && !st_q.eng1)
    |-> maintIrq)
    else $error("maint missing g1 off");

  chk_maint_g1_on: assert property (@(posedge ref_clk) disable iff (!rstn)
    (st_q.ctl[0] && st_q.ctl[6] && st_q.eng1)
    |-> maintIrq)
    else $error("maint missing g1 on");

  chk_maint_g0_off: assert property (@(posedge ref_clk) disable iff (!rstn)
    (st_q.ctl[0] && st_q.ctl[5] && !st_q.eng0)
    |-> maintIrq)
    else $error("maint missing g0 off");

  chk_maint_g0_on: assert property (@(posedge ref_clk) disable iff (!rstn)
    (st_q.ctl[0] && st_q.ctl[4] && st_q.eng0)
    |-> maintIrq)
    else $error("maint missing g0 on");

  chk_maint_none_pend: assert property (@(posedge ref_clk) disable iff (!rstn)
    (st_q.ctl[0] && st_q.ctl[3] && listPending == 4'h0)
    |-> maintIrq)
    else $error("maint missing np");

  chk_maint_count: assert property (@(posedge ref_clk) disable iff (!rstn)
    (st_q.ctl[0] && st_q.ctl[2] && st_q.count != 5'h00)
    |-> maintIrq)
    else $error("maint missing cnt");

  chk_maint_underflow: assert property (@(posedge ref_clk) disable iff (!rstn)
    (st_q.ctl[0] && st_q.ctl[1] && $countones(listValid) <= 1)
    |-> maintIrq)
    else $error("maint missing underflow");

  chk_maint_gated: assert property (@(posedge ref_clk) disable iff (!rstn)
    !vifEnable
    |-> !maintIrq)
    else $error("maint while disabled");

  chk_maint_exact: assert property (@(posedge ref_clk) disable iff (!rstn)
    1'b1
    |-> maintIrq == expMaint)
    else $error("maint differs from enabled conditions");

  chk_maint_quiet: assert property (@(posedge ref_clk) disable iff (!rstn)
    (st_q.ctl[7:1] == 7'h00)
    |-> !maintIrq)
    else $error("maint with no condition enabled");

  chk_vtr_read: assert property (@(posedge ref_clk) disable iff (!rstn)
    (regRead && regAddr == vihc_pkg::ADDR_VTR)
    |=> regRdata == 32'h9028_0003)
    else $error("bad type read");

  chk_vtr_widths: assert property (@(posedge ref_clk) disable iff (!rstn)
    (regRead && regAddr == vihc_pkg::ADDR_VTR)
    |=> regRdata[31:29] == 3'h4 && regRdata[28:26] == 3'h4)
    else $error("bad priority widths");

  chk_vtr_ident: assert property (@(posedge ref_clk) disable iff (!rstn)
    (regRead && regAddr == vihc_pkg::ADDR_VTR)
    |=> regRdata[25:22] == 4'h0)
    else $error("bad identifier or error support field");

  chk_vtr_affinity: assert property (@(posedge ref_clk) disable iff (!rstn)
    (regRead && regAddr == vihc_pkg::ADDR_VTR)
    |=> regRdata[21] && !regRdata[20])
    else $error("bad affinity or injection field");

  chk_vtr_deact: assert property (@(posedge ref_clk) disable iff (!rstn)
    (regRead && regAddr == vihc_pkg::ADDR_VTR)
    |=> regRdata[19] && regRdata[18:5] == 14'h0000)
    else $error("bad deactivate trap support field");

  chk_bp1_common: assert property (@(posedge ref_clk) disable iff (!rstn)
    (regRead && regAddr == vihc_pkg::ADDR_BPR1 && st_q.cbpr && st_q.bp0 == 3'h7)
    |=> regRdata[2:0] == 3'h7)
    else $error("bp1 not saturated");

  chk_bp1_plus_one: assert property (@(posedge ref_clk) disable iff (!rstn)
    (regRead && regAddr == vihc_pkg::ADDR_BPR1 && st_q.cbpr && st_q.bp0 != 3'h7)
    |=> regRdata[2:0] == $past(st_q.bp0) + 3'h1)
    else $error("bp1 view not bp0 plus one");

  chk_bp1_plain: assert property (@(posedge ref_clk) disable iff (!rstn)
    (regRead && regAddr == vihc_pkg::ADDR_BPR1 && !st_q.cbpr)
    |=> regRdata == {29'h0000_0000, $past(st_q.bp1)})
    else $error("bp1 view not own value");

  chk_bp1_ignored: assert property (@(posedge ref_clk) disable iff (!rstn)
    (regWrite && regAddr == vihc_pkg::ADDR_BPR1 && st_q.cbpr)
    |=> st_q.bp1 == $past(st_q.bp1))
    else $error("bp1 written in common mode");

  chk_eff_bp: assert property (@(posedge ref_clk) disable iff (!rstn)
    st_q.cbpr
    |-> effBinpointG1 == st_q.bp0)
    else $error("group 1 not using bp0");

  chk_bp0_min: assert property (@(posedge ref_clk) disable iff (!rstn)
    1'b1
    |-> st_q.bp0 >= 3'h2 && st_q.bp1 >= 3'h3)
    else $error("binary point below minimum");

  chk_bp0_clamp: assert property (@(posedge ref_clk) disable iff (!rstn)
    (regWrite && regAddr == vihc_pkg::ADDR_VMCR && regWdata[23:21] < 3'h2)
    |=> st_q.bp0 == 3'h2)
    else $error("bp0 not clamped");

  chk_bp1_clamp: assert property (@(posedge ref_clk) disable iff (!rstn)
    (regWrite && regAddr == vihc_pkg::ADDR_VMCR && regWdata[20:18] < 3'h3)
    |=> st_q.bp1 == 3'h3)
    else $error("bp1 not clamped");

  chk_vmcr_write: assert property (@(posedge ref_clk) disable iff (!rstn)
    (regWrite && regAddr == vihc_pkg::ADDR_VMCR)
    |=> virtualPriorityMask == $past(regWdata[31:24]) && virtualEoiSplitMode == $past(regWdata[9]))
    else $error("mask or eoi mode not stored");

  chk_vmcr_reserved: assert property (@(posedge ref_clk) disable iff (!rstn)
    (regRead && regAddr == vihc_pkg::ADDR_VMCR)
    |=> regRdata[17:10] == 8'h00 && regRdata[8:5] == 4'h0 && !regRdata[2])
    else $error("vm reserved bits not zero");

  chk_vmcr_fiq: assert property (@(posedge ref_clk) disable iff (!rstn)
    (regRead && regAddr == vihc_pkg::ADDR_VMCR)
    |=> regRdata[3])
    else $error("fast interrupt bit not one");

  chk_group_enables: assert property (@(posedge ref_clk) disable iff (!rstn)
    (regWrite && regAddr == vihc_pkg::ADDR_VMCR)
    |=> virtualGroup1Enable == $past(regWdata[1]) && virtualGroup0Enable == $past(regWdata[0]))
    else $error("group enables not stored");

  chk_vif_write: assert property (@(posedge ref_clk) disable iff (!rstn)
    (regWrite && regAddr == vihc_pkg::ADDR_HCR)
    |=> vifEnable == $past(regWdata[0]))
    else $error("interface enable not stored");

  chk_hcr_reserved: assert property (@(posedge ref_clk) disable iff (!rstn)
    (regRead && regAddr == vihc_pkg::ADDR_HCR)
    |=> regRdata[26:15] == 12'h000 && !regRdata[13] && regRdata[9:8] == 2'b00)
    else $error("control reserved bits not zero");

  chk_hcr_count_read: assert property (@(posedge ref_clk) disable iff (!rstn)
    (regRead && regAddr == vihc_pkg::ADDR_HCR)
    |=> regRdata[31:27] == $past(st_q.count))
    else $error("count field misread");

  chk_deact_trap: assert property (@(posedge ref_clk) disable iff (!rstn)
    (el1NonSecure && accDeactWrite && st_q.ctl[13])
    |-> trapToEl2)
    else $error("deactivate trap missing");

  chk_deact_no_trap: assert property (@(posedge ref_clk) disable iff (!rstn)
    (accDeactWrite && !st_q.ctl[13] && !accGroup0 && !accGroup1 && !accCommon)
    |-> !trapToEl2)
    else $error("deactivate trapped while off");

  chk_trap_g1: assert property (@(posedge ref_clk) disable iff (!rstn)
    (el1NonSecure && accGroup1 && st_q.ctl[12])
    |-> trapToEl2)
    else $error("group 1 trap missing");

  chk_trap_g0: assert property (@(posedge ref_clk) disable iff (!rstn)
    (el1NonSecure && accGroup0 && st_q.ctl[11])
    |-> trapToEl2)
    else $error("group 0 trap missing");

  chk_trap_common: assert property (@(posedge ref_clk) disable iff (!rstn)
    (el1NonSecure && accCommon && st_q.ctl[10])
    |-> trapToEl2)
    else $error("common trap missing");

  chk_trap_secure: assert property (@(posedge ref_clk) disable iff (!rstn)
    !el1NonSecure
    |-> !trapToEl2)
    else $error("trap outside non-secure el1");

  chk_trap_exact: assert property (@(posedge ref_clk) disable iff (!rstn)
    1'b1
    |-> trapToEl2 == expTrap)
    else $error("trap differs from enabled traps");

  chk_count_write: assert property (@(posedge ref_clk) disable iff (!rstn)
    (regWrite && regAddr == vihc_pkg::ADDR_HCR && !deactUnmatched && !deactMatched)
    |=> st_q.count == $past(regWdata[31:27]))
    else $error("count not written");

  chk_count_inc: assert property (@(posedge ref_clk) disable iff (!rstn)
    (deactUnmatched && !deactMatched && !regWrite && st_q.count != 5'h1F)
    |=> st_q.count == $past(st_q.count) + 5'h01)
    else $error("count not incremented");

  chk_count_dec: assert property (@(posedge ref_clk) disable iff (!rstn)
    (deactMatched && !deactUnmatched && !regWrite && st_q.count != 5'h00)
    |=> st_q.count == $past(st_q.count) - 5'h01)
    else $error("count not decremented");

  chk_count_sat: assert property (@(posedge ref_clk) disable iff (!rstn)
    (deactUnmatched && !deactMatched && !regWrite && st_q.count == 5'h1F)
    |=> st_q.count == 5'h1F)
    else $error("count wrapped");

  cov_maint_rise: cover property (@(posedge ref_clk) disable iff (!rstn) $rose(maintIrq));
  cov_trap_g1: cover property (@(posedge ref_clk) disable iff (!rstn) el1NonSecure && accGroup1 && trapToEl2);
  cov_bp1_common: cover property (@(posedge ref_clk) disable iff (!rstn)
    regRead && regAddr == vihc_pkg::ADDR_BPR1 && st_q.cbpr);
  cov_count_two: cover property (@(posedge ref_clk) disable iff (!rstn)
    st_q.count == 5'h02 && maintIrq);
  cov_underflow: cover property (@(posedge ref_clk) disable iff (!rstn)
    st_q.ctl[1] && listValid == 4'h1 && maintIrq);
endmodule : vihc_ctrl

//--- logic/vihc_pkg.sv
// vihc_pkg: constants for the hypervisor-side virtual interrupt control block.
// assumes a plain register port with one-cycle strobes and read data one cycle later.
package vihc_pkg;
  localparam logic [3:0] ADDR_HCR = 4'h0;
  localparam logic [3:0] ADDR_VMCR = 4'h4;
  localparam logic [3:0] ADDR_VTR = 4'h8;
  localparam logic [3:0] ADDR_BPR1 = 4'hC;
  localparam int HCR_CNT_LSB = 27;
  localparam int HCR_TRAP_DEACTIVATE_WRITES = 14;
  localparam int HCR_TRAP_GROUP1_ACCESSES = 12;
  localparam int HCR_TRAP_GROUP0_ACCESSES = 11;
  localparam int HCR_TC = 10;
  localparam int HCR_MAINT_LSB = 1;
  localparam int HCR_EN = 0;
  localparam int VM_PMR_LSB = 24;
  localparam int VM_BP0_LSB = 21;
  localparam int VM_BP1_LSB = 18;
  localparam int VM_EOIM = 9;
  localparam int VM_CBPR = 4;
  localparam int VM_FIQ = 3;
  localparam int VM_ENG1 = 1;
  localparam int VM_ENG0 = 0;
  localparam logic [2:0] BP0_MIN = 3'h2;
  localparam logic [2:0] BP1_MIN = 3'h3;
  localparam logic [2:0] BP_MAX = 3'h7;
  localparam logic [31:0] HCR_RESET = 32'h0000_0000;
  localparam logic [31:0] HCR_WMASK = 32'h0000_5CFF;
  localparam logic [31:0] VTR_VALUE = 32'h9028_0003;
  localparam int LIST_ENTRIES = 4;
endpackage : vihc_pkg

//--- verif/tb_vihc_ctrl.sv
// tb_vihc_ctrl: self-checking bench for the virtual interrupt hypervisor control block.
// assumes vihc_ctrl answers reads one cycle late and applies writes on the next cycle.
`timescale 1ns/1ps
module tb_vihc_ctrl;
  typedef struct packed {
    logic [31:0] hcr;
    logic [31:0] vmcr;
    logic [3:0] lv;
    logic [3:0] lp;
    logic [4:0] acc;
    logic trap;
    logic maint;
  } vihc_row_t;
  logic ref_clk = 0, rstn = 0, regWrite = 0, regRead = 0, deactUnmatched = 0, deactMatched = 0;
  logic [3:0] regAddr = 4'h0, listValid = 4'hF, listPending = 4'hF;
  logic [31:0] regWdata = 32'h0000_0000, regRdata;
  logic [4:0] acc = 5'h00;
  logic trapToEl2, maintIrq, vifEnable, virtualEoiSplitMode, virtualGroup0Enable, virtualGroup1Enable, g0AsFastIrq;
  logic [7:0] virtualPriorityMask;
  logic [2:0] effBinpointG1;
  int errCount = 0, nTests = 0;
  // acc order: non-secure el1, deactivate write, group 0, group 1, common
  vihc_row_t rows [23] = '{
    '{32'h81, 0, 4'hF, 4'hF, 5'h00, 0, 1}, '{32'h81, 2, 4'hF, 4'hF, 5'h00, 0, 0}, '{32'h41, 2, 4'hF, 4'hF, 5'h00, 0, 1},
    '{32'h41, 0, 4'hF, 4'hF, 5'h00, 0, 0}, '{32'h21, 0, 4'hF, 4'hF, 5'h00, 0, 1}, '{32'h21, 1, 4'hF, 4'hF, 5'h00, 0, 0},
    '{32'h11, 1, 4'hF, 4'hF, 5'h00, 0, 1}, '{32'h11, 0, 4'hF, 4'hF, 5'h00, 0, 0}, '{32'h09, 0, 4'hF, 4'h0, 5'h00, 0, 1},
    '{32'h09, 0, 4'hF, 4'h2, 5'h00, 0, 0}, '{32'h03, 0, 4'h1, 4'hF, 5'h00, 0, 1}, '{32'h03, 0, 4'h3, 4'hF, 5'h00, 0, 0},
    '{32'h03, 0, 4'h0, 4'hF, 5'h00, 0, 1}, '{32'h80, 0, 4'hF, 4'hF, 5'h00, 0, 0}, '{32'h0800_0005, 0, 4'hF, 4'hF, 5'h00, 0, 1},
    '{32'h05, 0, 4'hF, 4'hF, 5'h00, 0, 0}, '{32'h4001, 0, 4'hF, 4'hF, 5'h18, 1, 0}, '{32'h4001, 0, 4'hF, 4'hF, 5'h08, 0, 0},
    '{32'h1001, 0, 4'hF, 4'hF, 5'h12, 1, 0}, '{32'h0801, 0, 4'hF, 4'hF, 5'h14, 1, 0}, '{32'h0401, 0, 4'hF, 4'hF, 5'h11, 1, 0},
    '{32'h0001, 0, 4'hF, 4'hF, 5'h1F, 0, 0}, '{32'h0C01, 0, 4'hF, 4'hF, 5'h12, 0, 0}};

  vihc_ctrl dut (.ref_clk(ref_clk), .rstn(rstn), .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
    .regRead(regRead), .regRdata(regRdata), .listValid(listValid), .listPending(listPending),
    .deactUnmatched(deactUnmatched), .deactMatched(deactMatched), .el1NonSecure(acc[4]), .accDeactWrite(acc[3]),
    .accGroup0(acc[2]), .accGroup1(acc[1]), .accCommon(acc[0]), .trapToEl2(trapToEl2), .maintIrq(maintIrq),
    .vifEnable(vifEnable), .virtualPriorityMask(virtualPriorityMask), .effBinpointG1(effBinpointG1),
    .virtualEoiSplitMode(virtualEoiSplitMode), .virtualGroup0Enable(virtualGroup0Enable),
    .virtualGroup1Enable(virtualGroup1Enable), .g0AsFastIrq(g0AsFastIrq));

  initial begin
    forever #12.5 ref_clk = ~ref_clk;
  end

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    nTests++;
    if (seen !== exp) begin
      errCount++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    regWrite <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge ref_clk);
    regWrite <= 1'b0;
  endtask : wr

  // read data stands only in the cycle after the strobe, so it is sampled there
  task rd(input logic [3:0] a, input logic [31:0] exp);
    @(posedge ref_clk);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge ref_clk);
    regRead <= 1'b0;
    #1 chk(regRdata, exp);
  endtask : rd

  task pulse(input logic up);
    @(posedge ref_clk);
    if (up) deactUnmatched <= 1'b1; else deactMatched <= 1'b1;
    @(posedge ref_clk);
    deactUnmatched <= 1'b0;
    deactMatched <= 1'b0;
  endtask : pulse

  task complete_run;
    $display("comparisons=%0d mismatches=%0d", nTests, errCount);
    if (errCount == 0 && nTests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : complete_run

  initial begin
    repeat (3000) @(posedge ref_clk);
    errCount++;
    complete_run;
  end

  initial begin
    repeat (4) @(posedge ref_clk);
    rstn <= 1'b1;
    rd(4'h8, 32'h9028_0003);
    rd(4'h0, 32'h0000_0000);
    rd(4'h4, 32'h004C_0008);
    rd(4'h1, 32'h0000_0000);
    foreach (rows[i]) begin
      wr(4'h0, rows[i].hcr);
      wr(4'h4, rows[i].vmcr);
      @(posedge ref_clk);
      listValid <= rows[i].lv;
      listPending <= rows[i].lp;
      acc <= rows[i].acc;
      @(posedge ref_clk);
      #1 chk(32'(maintIrq), 32'(rows[i].maint));
      chk(32'(trapToEl2), 32'(rows[i].trap));
      chk(32'(vifEnable), 32'(rows[i].hcr[0]));
    end
    wr(4'h0, 32'hFFFF_FFFF);
    rd(4'h0, 32'hF800_5CFF);
    wr(4'h4, 32'hFFFF_FFFF);
    rd(4'h4, 32'hFFFC_021B);
    chk(32'({virtualPriorityMask, virtualEoiSplitMode, virtualGroup1Enable, virtualGroup0Enable}), 32'h7FF);
    chk(32'(g0AsFastIrq), 32'h0000_0001);
    chk(32'(effBinpointG1), 32'h0000_0007);
    rd(4'hC, 32'h0000_0007);
    wr(4'h4, 32'h0080_0010);
    rd(4'hC, 32'h0000_0005);
    wr(4'hC, 32'h0000_0006);
    rd(4'hC, 32'h0000_0005);
    wr(4'h4, 32'h0000_0000);
    rd(4'h4, 32'h004C_0008);
    wr(4'hC, 32'h0000_0006);
    rd(4'hC, 32'h0000_0006);
    wr(4'h0, 32'h0000_0005);
    pulse(1'b1);
    pulse(1'b1);
    rd(4'h0, 32'h1000_0005);
    chk(32'(maintIrq), 32'h0000_0001);
    pulse(1'b0);
    pulse(1'b0);
    rd(4'h0, 32'h0000_0005);
    chk(32'(maintIrq), 32'h0000_0000);
    // mid-run reset must bring every field back to its reset value
    wr(4'h0, 32'hFFFF_FFFF);
    @(posedge ref_clk);
    rstn <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rstn <= 1'b1;
    rd(4'h0, 32'h0000_0000);
    chk(32'(maintIrq), 32'h0000_0000);
    rd(4'h4, 32'h004C_0008);
    complete_run;
  end
endmodule : tb_vihc_ctrl
